// *** shared/ssfoc_consts.vh ***
// Constants for the speed sensor fault and output control block
// Assumes a 125 MHz core clock
`ifndef SSFOC_CONSTS_VH
`define SSFOC_CONSTS_VH

`define SSFOC_CLK_MHZ        125
// Fault hold time in microseconds; longer than the 1 ms fault band time
`define SSFOC_HOLD_US        1100
// Hold and pulse counts are microseconds times clock MHz, sized to the counter
`define SSFOC_HOLD_CYC       18'h2191c
`define SSFOC_CNT_W          18
`define SSFOC_CNT_ONE        18'h00001
// Default output pulse width in microseconds and cycles
`define SSFOC_PULSE_US       45
`define SSFOC_PULSE_CYC      18'h015f9
// Output level codes
`define SSFOC_LVL_LOW        2'h0
`define SSFOC_LVL_HIGH       2'h1
`define SSFOC_LVL_FAULT_HIGH 2'h2
// Protocol codes
`define SSFOC_PROTO_LEVEL    2'h0
`define SSFOC_PROTO_PULSE    2'h1
// Recalibration factor: amplitude above twice the calibrated peak
`define SSFOC_RECAL_SHIFT    1
`define SSFOC_AMP_W          12

`endif

// *** logic/ssfoc_chan.v ***
// One output channel: pulse timing and collision blocking
// Assumes transition requests are single-cycle pulses in the clk domain
`include "ssfoc_consts.vh"
`default_nettype none

module ssfoc_chan
(
  input  wire       clk,
  input  wire       rst,
  input  wire       pulse_mode,
  input  wire       suppress,
  input  wire       req,
  input  wire       level_in,
  output reg        level,
  output reg        busy
);

  reg [`SSFOC_CNT_W-1:0] count;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level <= 1'b0;
      busy  <= 1'b0;
      count <= {`SSFOC_CNT_W{1'b0}};
    end
    else if (suppress)
    begin
      // Normal transitions dropped while the fault is held
      level <= 1'b0;
      busy  <= 1'b0;
      count <= {`SSFOC_CNT_W{1'b0}};
    end
    else if (pulse_mode)
    begin
      if (busy)
      begin
        // New transitions blocked until the pulse is complete
        if (count == `SSFOC_CNT_ONE)
        begin
          busy  <= 1'b0;
          level <= 1'b0;
        end
        count <= count - `SSFOC_CNT_ONE;
      end
      else if (req)
      begin
        busy  <= 1'b1;
        level <= 1'b1;
        count <= `SSFOC_PULSE_CYC;
      end
      else
        // Pulse outputs idle low, whatever a level protocol left behind
        level <= 1'b0;
    end
    else
    begin
      // Level protocols follow the request directly
      busy  <= 1'b0;
      count <= {`SSFOC_CNT_W{1'b0}};
      if (req)
        level <= level_in;
    end
  end

endmodule

`default_nettype wire

// *** logic/ssfoc_top.v ***
// Fault signalling, auto reset, recalibration and output control
// Assumes synchronous inputs and rst from power-on or undervoltage
`include "ssfoc_consts.vh"
`default_nettype none

module ssfoc_top
(
  input  wire                   clk,
  input  wire                   rst,
  input  wire [7:0]             diag_fault,
  input  wire [7:0]             diag_clearable,
  input  wire [1:0]             protocol,
  input  wire                   req_a,
  input  wire                   lvl_a,
  input  wire                   req_b,
  input  wire                   lvl_b,
  input  wire                   calibrated,
  input  wire [`SSFOC_AMP_W-1:0] amp_tracked,
  input  wire [`SSFOC_AMP_W-1:0] amp_cal,
  output reg  [1:0]             out_a,
  output reg  [1:0]             out_b,
  output reg                    fault_active,
  output reg                    fault_latched,
  output reg                    ctrl_reset,
  output reg                    recal_req,
  output reg                    pulse_busy
);

  // One-hot fault sequence states
  localparam ST_NORMAL = 3'b001;
  localparam ST_HOLD   = 3'b010;
  localparam ST_RESET  = 3'b100;

  reg  [2:0]              state;
  reg  [`SSFOC_CNT_W-1:0] hold_cnt;
  reg                     clearable;

  reg  [2:0]              next_state;
  reg  [`SSFOC_CNT_W-1:0] next_hold_cnt;
  reg                     next_clearable;
  reg                     next_fault_active;
  reg                     next_fault_latched;
  reg                     next_ctrl_reset;
  reg  [1:0]              next_out_a;
  reg  [1:0]              next_out_b;
  reg                     next_pulse_busy;
  reg                     next_recal_req;

  wire                    any_fault;
  wire                    any_clear;
  wire                    hard_seen;
  wire                    hold_done;
  wire                    pulse_mode;
  wire                    suppress;
  wire                    lvl_out_a;
  wire                    lvl_out_b;
  wire                    busy_a;
  wire                    busy_b;
  wire                    amp_over;
  wire [`SSFOC_AMP_W:0]   amp_limit;

  // A fault is clearable only if every active monitor is in the subset
  assign any_fault  = |diag_fault;
  assign any_clear  = ~|(diag_fault & ~diag_clearable);
  // Some active monitor lies outside the clearable subset
  assign hard_seen  = any_fault & ~any_clear;
  assign hold_done  = (hold_cnt == {`SSFOC_CNT_W{1'b0}});
  assign pulse_mode = (protocol == `SSFOC_PROTO_PULSE);
  assign suppress   = (state != ST_NORMAL) | any_fault;
  // Recalibration threshold is twice the calibrated peak
  assign amp_limit  = {1'b0, amp_cal} << `SSFOC_RECAL_SHIFT;
  assign amp_over   = ({1'b0, amp_tracked} > amp_limit);

  ssfoc_chan u_chan_a
  (
    .clk        (clk),
    .rst        (rst),
    .pulse_mode (pulse_mode),
    .suppress   (suppress),
    .req        (req_a),
    .level_in   (lvl_a),
    .level      (lvl_out_a),
    .busy       (busy_a)
  );

  ssfoc_chan u_chan_b
  (
    .clk        (clk),
    .rst        (rst),
    .pulse_mode (pulse_mode),
    .suppress   (suppress),
    .req        (req_b),
    .level_in   (lvl_b),
    .level      (lvl_out_b),
    .busy       (busy_b)
  );

  // Fault sequence: entry, hold count, then self reset or permanent latch
  always @*
  begin
    // Defaults hold every register except ctrl_reset, which defaults low
    next_state         = state;
    next_hold_cnt      = hold_cnt;
    next_clearable     = clearable;
    next_fault_active  = fault_active;
    next_fault_latched = fault_latched;
    next_ctrl_reset    = 1'b0;
    case (state)
      ST_NORMAL:
      begin
        // Outputs already follow the fault through suppress
        if (any_fault)
        begin
          next_state        = ST_HOLD;
          next_hold_cnt     = `SSFOC_HOLD_CYC;
          next_clearable    = any_clear;
          next_fault_active = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // A hard monitor seen even in the last hold cycle blocks the reset
        if (hard_seen)
          next_clearable = 1'b0;
        if (!hold_done)
          next_hold_cnt = hold_cnt - `SSFOC_CNT_ONE;
        else if (next_clearable)
        begin
          next_state      = ST_RESET;
          next_ctrl_reset = 1'b1;
        end
        else
          // Hard fault: outputs stay in the fault band until rst
          next_fault_latched = 1'b1;
      end
      ST_RESET:
      begin
        // One cycle of controller reset; a new fault waits for NORMAL
        next_state        = ST_NORMAL;
        next_fault_active = 1'b0;
      end
      default:
      begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  // Sequence registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state         <= ST_NORMAL;
      hold_cnt      <= {`SSFOC_CNT_W{1'b0}};
      clearable     <= 1'b0;
      fault_active  <= 1'b0;
      fault_latched <= 1'b0;
      ctrl_reset    <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      hold_cnt      <= next_hold_cnt;
      clearable     <= next_clearable;
      fault_active  <= next_fault_active;
      fault_latched <= next_fault_latched;
      ctrl_reset    <= next_ctrl_reset;
    end
  end

  // Fault overrides both outputs with the high fault band
  always @*
  begin
    if (suppress)
    begin
      next_out_a = `SSFOC_LVL_FAULT_HIGH;
      next_out_b = `SSFOC_LVL_FAULT_HIGH;
    end
    else
    begin
      next_out_a = lvl_out_a ? `SSFOC_LVL_HIGH : `SSFOC_LVL_LOW;
      next_out_b = lvl_out_b ? `SSFOC_LVL_HIGH : `SSFOC_LVL_LOW;
    end
    next_pulse_busy = busy_a | busy_b;
    // No recalibration request while the outputs carry a fault
    next_recal_req  = calibrated & ~suppress & amp_over;
  end

  // Every output leaves straight from a flop
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_a      <= `SSFOC_LVL_LOW;
      out_b      <= `SSFOC_LVL_LOW;
      pulse_busy <= 1'b0;
      recal_req  <= 1'b0;
    end
    else
    begin
      out_a      <= next_out_a;
      out_b      <= next_out_b;
      pulse_busy <= next_pulse_busy;
      recal_req  <= next_recal_req;
    end
  end

endmodule

`default_nettype wire

// *** verif/ssfoc_ctrl_model.sv ***
// Controller model that watches channel a for a fault band
// Assumes out_a code 2 is the high fault band
`default_nettype none
module ssfoc_ctrl_model
(
  input  wire logic       clk,
  input  wire logic [1:0] out_a,
  output var  logic       fault_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  initial fault_seen = 1'b0;
  always @(posedge clk)
  begin
    // Shorter stays are transitions
    n <= (out_a == 2'h2) ? n + 1 : 0;
    if (n > 125000)
      fault_seen <= 1'b1;
  end
endmodule
`default_nettype wire

// *** verif/ssfoc_asserts.sv ***
// Port checker for ssfoc_top
// Assumes it is bound into ssfoc_top
`default_nettype none
module ssfoc_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  diag_fault,
  input wire logic [1:0]  protocol,
  input wire logic        req_a,
  input wire logic        lvl_a,
  input wire logic        calibrated,
  input wire logic [11:0] amp_tracked,
  input wire logic [11:0] amp_cal,
  input wire logic [1:0]  out_a,
  input wire logic [1:0]  out_b,
  input wire logic        fault_active,
  input wire logic        fault_latched,
  input wire logic        ctrl_reset,
  input wire logic        recal_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] hc = 18'h0;
  logic [12:0] pc = 13'h0;
  always_ff @(posedge clk) hc <= fault_active ? hc + 18'h1 : 18'h0;
  always_ff @(posedge clk) pc <= (out_a == 2'h1) ? pc + 13'h1 : 13'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_fault_entry: assert property (|diag_fault && !fault_active |=>
    fault_active && out_a == 2'h2 && out_b == 2'h2) else $error("entry");
  a_hold_out: assert property (fault_active |-> out_a == 2'h2 && out_b == 2'h2)
    else $error("hold");
  a_hold_len: assert property (ctrl_reset |-> hc == 18'h2191d)
    else $error("length");
  a_reset_once: assert property (ctrl_reset |=> !ctrl_reset && !fault_active)
    else $error("reset");
  a_latch_noclr: assert property (fault_latched |-> !ctrl_reset && out_a == 2'h2)
    else $error("latch");
  a_recal_cmp: assert property (recal_req |-> $past(calibrated) &&
    {1'b0, $past(amp_tracked)} > {$past(amp_cal), 1'b0}) else $error("recal");
  a_pulse_width: assert property (protocol == 2'h1 && $past(out_a) == 2'h1
    && out_a == 2'h0 |-> pc == 13'h15f9) else $error("width");
  a_level_follow: assert property (protocol != 2'h1 && req_a && !fault_active
    && !diag_fault ##1 !diag_fault |=> out_a == {1'b0, $past(lvl_a, 2)}) else $error("level");
  c_reset: cover property (ctrl_reset);
  c_pulse: cover property (protocol == 2'h1 && $rose(out_a == 2'h1));
  c_recal: cover property (recal_req);
endmodule
bind ssfoc_top ssfoc_chk ssfoc_chk_i (.clk, .rst, .diag_fault, .protocol, .req_a, .lvl_a,
  .calibrated, .amp_tracked, .amp_cal, .out_a, .out_b, .fault_active, .fault_latched,
  .ctrl_reset, .recal_req);
`default_nettype wire

// *** verif/test_speed_sensor_fault_output_ctrl.sv ***
// Bench for the fault and output control block
// Assumes the controller model watches channel a
`default_nettype none
module test_speed_sensor_fault_output_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, req_a = 0, lvl_a = 0, req_b = 0, lvl_b = 0, cal = 0;
  logic [7:0] df = 8'h0, dc = 8'h0;
  logic [1:0] pr = 2'h0, out_a, out_b;
  logic [11:0] at = 12'h0, ac = 12'h0;
  logic fa, fl, cr, rq, pb, seen;
  int n_errors = 0, checks_done = 0, k;
  always #4 clk = ~clk;
  ssfoc_top ssfoc_top_i (.clk, .rst, .diag_fault(df), .diag_clearable(dc), .protocol(pr),
    .req_a, .lvl_a, .req_b, .lvl_b, .calibrated(cal), .amp_tracked(at), .amp_cal(ac),
    .out_a, .out_b, .fault_active(fa), .fault_latched(fl), .ctrl_reset(cr),
    .recal_req(rq), .pulse_busy(pb));
  ssfoc_ctrl_model ssfoc_ctrl_model_i (.clk, .out_a, .fault_seen(seen));
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string s, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task t_level;
    for (int p = 0; p < 4; p++)
    begin
      if (p == 1)
        continue;
      pr = p[1:0];
      lvl_a = ~p[0];
      lvl_b = lvl_a;
      {req_a, req_b} = 2'h3;
      step(1);
      {req_a, req_b} = 2'h0;
      step(2);
      chk("lvl", {1'b0, lvl_b, 1'b0, lvl_a}, {out_b, out_a});
    end
    $display("level done");
  endtask
  task t_pulse;
    pr = 2'h1;
    step(2);
    {req_a, req_b} = 2'h3;
    step(1);
    {req_a, req_b} = 2'h0;
    step(2);
    chk("pulse", 5'h15, {pb, out_b, out_a});
    step(99);
    req_a = 1;
    step(1);
    req_a = 0;
    step(5523);
    chk("width", 1, out_a);
    step(1);
    chk("end", 0, {pb, out_a});
    step(10);
    chk("refused", 0, out_a);
    $display("pulse done");
  endtask
  task t_recal;
    {cal, ac, at} = {1'b1, 12'h100, 12'h201};
    step(2);
    chk("recal", 1, rq);
    at = 12'h200;
    step(2);
    chk("norecal", 0, rq);
    $display("recal done");
  endtask
  task t_fault;
    {dc, df, pr, lvl_a} = {16'h0101, 2'h0, 1'b1};
    step(1);
    {df, req_a} = 9'h1;
    step(1);
    req_a = 0;
    chk("fault", 5'h1a, {fa, out_b, out_a});
    chk("unseen", 0, seen);
    k = 0;
    while (cr !== 1'b1 && k < 140000)
    begin
      step(1);
      k++;
    end
    chk("hold", 137500, k);
    step(2);
    chk("after", 0, {fa, fl, out_a});
    chk("seen", 1, seen);
    $display("fault done");
  endtask
  task t_latch;
    {dc, df} = 16'h0101;
    step(1);
    df = 8'h2;
    step(1);
    df = 8'h0;
    chk("hard", 5'h1a, {fa, out_b, out_a});
    k = 0;
    while (fl !== 1'b1 && k < 140000)
    begin
      step(1);
      k++;
    end
    chk("latch", 137500, k);
    step(2);
    chk("stuck", 6'h3a, {fa, fl, out_b, out_a});
    rst = 1;
    step(2);
    rst = 0;
    step(1);
    chk("cleared", 0, {fa, fl, cr, out_b, out_a});
    $display("latch done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    step(12);
    rst = 0;
    step(1);
    t_level;
    t_pulse;
    t_recal;
    t_fault;
    t_latch;
    report_and_stop;
  end
  initial
  begin
    repeat (300000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
